// File: design/cs_unit_pkg.sv
// Purpose: Shared constants for the chip-select pin control unit
// Assumes: 8-bit register offsets on a plain strobe port, 32-bit words
// Notes:   Pin index 12 stands for the boot select pin
package cs_unit_pkg;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int NUM_PINS    = 12;
	localparam int NUM_REGIONS = 6;
	localparam int BOOT_PIN    = 12;
	localparam int FIRST_WO_CE = 6;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_REGION     = 8'h00;
	localparam logic [7:0] REGION_STRIDE  = 8'h08;
	localparam logic [7:0] OFF_REGION_OPT = 8'h04;
	localparam logic [7:0] OFF_PIN        = 8'h40;
	localparam logic [7:0] PIN_STRIDE     = 8'h04;
	localparam logic [7:0] OFF_SUB        = 8'h80;
	localparam logic [7:0] OFF_PORT_SEL   = 8'h90;
	localparam logic [7:0] OFF_PORT_DAT   = 8'h94;
	localparam logic [7:0] OFF_STATUS     = 8'h98;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int F_BA_LSB   = 12;
	localparam int F_WAIT_LSB = 0;
	localparam int F_PIPE     = 3;
	localparam int F_W16      = 4;
	localparam int F_ROLE_LSB = 0;
	localparam int F_SEL_LSB  = 4;
	localparam int F_WP       = 0;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [19:0] RST_BASE   = 20'h00000;
	localparam logic [19:0] RST_MASK   = 20'h00000;
	localparam logic [2:0]  RST_WAIT   = 3'h7;
	localparam logic [2:0]  RST_SEL    = 3'h0;
	localparam logic [11:0] RST_PORT   = 12'h000;

	// ----------------------------------------
	// Pin roles
	// ----------------------------------------
	typedef enum logic [1:0] {
		ROLE_ALT = 2'h0,
		ROLE_CE  = 2'h1,
		ROLE_WE  = 2'h2,
		ROLE_OE  = 2'h3
	} role_t;

endpackage

// File: design/cs_unit.sv
// Purpose: Chip-select pin control: strobes, wait states, pipelining
// Assumes: Single bus master on the same clock; synchronous reset
// Notes:   Region 0 is the boot region; region r (1..5) belongs to pin r
//
// What this block does
// [RQ1] Pin role field picks CE, WE, OE, alternate
// [RQ2] Alternate pins drive address bit or port bit
// [RQ3] Boot select pin has no alternate function
// [RQ4] Boot pin resets as boot memory chip enable
// [RQ5] Pin 0 only WE/OE; resets as boot OE
// [RQ6] Pins 1-5 take any strobe; six CEs max
// [RQ7] Pins 6-11 only write or output enable
// [RQ8] Twelve select pins plus one boot pin
// [RQ9] Pin states undefined first two reset cycles
// [RQ10] CE asserts with address on external bus
// [RQ11] Non-pipelined region holds CE until done
// [RQ12] Pipelined slave captures address on CE edge
// [RQ13] WE only during write data phase
// [RQ14] Slave captures write data on WE edge
// [RQ15] OE only during reads; slave drives then
// [RQ16] Zero to seven wait states per region
// [RQ17] Two outstanding, different regions, one each
// [RQ18] Same-region address overlaps previous data phase
// [RQ19] Each region selects 16 or 32 bit port
// [RQ20] Boot region has two protection sub-levels
// [RQ21] Unit generates transfer handshakes itself
// [RQ22] Data order follows address order per slave
// [RQ23] Alternate pins never driven by strobe logic
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module cs_unit
	import cs_unit_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// Register port
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [31:0] reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic      [31:0] reg_rdata_out,
	// Access requests
	input  wire logic        req_valid_in,
	input  wire logic [31:0] req_addr_in,
	input  wire logic        req_write_in,
	output logic             aack_out,
	output logic             ta_out,
	output logic             err_out,
	// External bus side
	output logic      [31:0] ext_addr_out,
	output logic             ext_write_out,
	output logic             port16_out,
	output logic      [11:0] select_pin_out,
	output logic             boot_select_pin_n_out
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [NUM_REGIONS-1:0][19:0] base;
		logic [NUM_REGIONS-1:0][19:0] mask;
		logic [NUM_REGIONS-1:0][2:0]  wst;
		logic [NUM_REGIONS-1:0]       pipe;
		logic [NUM_REGIONS-1:0]       w16;
		logic [NUM_PINS:0][1:0]       role;
		logic [NUM_PINS:0][2:0]       sel;
		logic [1:0][19:0]             sub_base;
		logic [1:0][19:0]             sub_mask;
		logic [1:0]                   sub_wp;
		logic [11:0]                  port_sel;
		logic [11:0]                  port_dat;
		logic                         pend_v;
		logic [2:0]                   pend_rg;
		logic                         pend_wr;
		logic                         act_v;
		logic [2:0]                   act_rg;
		logic                         act_wr;
		logic [2:0]                   act_cnt;
		logic [31:0]                  ext_a;
		logic                         ext_wr;
		logic                         w16_o;
		logic                         aack;
		logic                         ta;
		logic                         err;
		logic [NUM_PINS:0]            pin_lvl;
		logic [31:0]                  rdata;
	} state_t;

	state_t s_q;
	state_t s_d;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		logic       hit;
		logic [2:0] hit_rg;
		logic       prot;
		logic       take;
		logic [2:0] rg;
		logic       on;
		s_d = s_q;
		hit = 1'b0;
		hit_rg = 3'h0;
		prot = 1'b0;
		take = 1'b0;
		rg = 3'h0;
		on = 1'b0;
		s_d.aack = 1'b0;
		s_d.err = 1'b0;

		// Region decode, lowest index wins; region enabled by its CE pin
		for (int r = NUM_REGIONS - 1; r >= 0; r--)
		begin
			on = (r == 0) ? (s_q.role[BOOT_PIN] == ROLE_CE) : (s_q.role[r] == ROLE_CE);
			if (on && (((req_addr_in[31:12] ^ s_q.base[r]) & s_q.mask[r]) == 20'h00000))
			begin
				hit = 1'b1;
				hit_rg = 3'(r);
			end
		end

		// Boot sub-level write protection
		for (int k = 0; k < 2; k++)
			if (hit && hit_rg == 3'h0 && req_write_in && s_q.sub_wp[k]
				&& (((req_addr_in[31:12] ^ s_q.sub_base[k]) & s_q.sub_mask[k]) == 20'h00000))
				prot = 1'b1; // RQ20

		// Data phase countdown; wait states end the access
		if (s_q.act_v)
		begin
			if (s_q.act_cnt == 3'h0)
				s_d.act_v = 1'b0;
			else
				s_d.act_cnt = s_q.act_cnt - 3'h1; // RQ16
		end

		// Address phase moves to data phase in order
		if (s_q.pend_v && !s_d.act_v)
		begin
			s_d.act_v = 1'b1; // RQ22
			s_d.act_rg = s_q.pend_rg;
			s_d.act_wr = s_q.pend_wr;
			s_d.act_cnt = s_q.wst[s_q.pend_rg];
			s_d.pend_v = 1'b0;
		end

		// Take a request: behind a pipelined region, two outstanding to different regions, or to the same region one cycle before its last data cycle
		if (req_valid_in && !s_q.aack && !s_q.err && !s_q.pend_v)
		begin
			if (!hit || prot)
				s_d.err = 1'b1; // RQ21
			else if (!s_q.act_v)
				take = 1'b1;
			else if (s_q.pipe[s_q.act_rg] && hit_rg != s_q.act_rg)
				take = 1'b1; // RQ17
			// Same region joins so its address phase meets the last data cycle
			else if (s_q.pipe[s_q.act_rg] && s_q.act_cnt == 3'h1)
				take = 1'b1; // RQ18
		end
		if (take)
		begin
			s_d.pend_v = 1'b1;
			s_d.pend_rg = hit_rg;
			s_d.pend_wr = req_write_in;
			s_d.ext_a = req_addr_in;
			s_d.ext_wr = req_write_in;
			s_d.aack = 1'b1; // RQ21
		end

		// Transfer acknowledge marks the last data phase cycle
		s_d.ta = s_d.act_v && s_d.act_cnt == 3'h0; // RQ21
		s_d.w16_o = s_d.act_v ? s_q.w16[s_d.act_rg] : s_q.w16[s_d.pend_rg]; // RQ19

		// Register writes
		if (reg_wr_in)
		begin
			for (int r = 0; r < NUM_REGIONS; r++)
			begin
				if (reg_addr_in == 8'(OFF_REGION + 8'(r) * REGION_STRIDE))
					s_d.base[r] = reg_wdata_in[31:F_BA_LSB];
				if (reg_addr_in == 8'(OFF_REGION + 8'(r) * REGION_STRIDE + OFF_REGION_OPT))
				begin
					s_d.mask[r] = reg_wdata_in[31:F_BA_LSB];
					s_d.wst[r] = reg_wdata_in[F_WAIT_LSB +: 3]; // RQ16
					s_d.pipe[r] = reg_wdata_in[F_PIPE];
					s_d.w16[r] = reg_wdata_in[F_W16]; // RQ19
				end
			end
			for (int p = 0; p <= NUM_PINS; p++)
				if (reg_addr_in == 8'(OFF_PIN + 8'(p) * PIN_STRIDE))
				begin
					s_d.sel[p] = reg_wdata_in[F_SEL_LSB +: 3];
					// Illegal roles leave the old role in place
					if (p == BOOT_PIN && reg_wdata_in[F_ROLE_LSB +: 2] == ROLE_ALT)
						s_d.role[p] = s_q.role[p]; // RQ3
					else if ((p == 0 || (p >= FIRST_WO_CE && p < BOOT_PIN))
						&& reg_wdata_in[F_ROLE_LSB +: 2] == ROLE_CE)
						s_d.role[p] = s_q.role[p]; // RQ5 RQ7
					else
						s_d.role[p] = reg_wdata_in[F_ROLE_LSB +: 2]; // RQ1 RQ6
				end
			for (int k = 0; k < 2; k++)
			begin
				if (reg_addr_in == 8'(OFF_SUB + 8'(k) * REGION_STRIDE))
					s_d.sub_base[k] = reg_wdata_in[31:F_BA_LSB];
				if (reg_addr_in == 8'(OFF_SUB + 8'(k) * REGION_STRIDE + OFF_REGION_OPT))
				begin
					s_d.sub_mask[k] = reg_wdata_in[31:F_BA_LSB];
					s_d.sub_wp[k] = reg_wdata_in[F_WP]; // RQ20
				end
			end
			if (reg_addr_in == OFF_PORT_SEL)
				s_d.port_sel = reg_wdata_in[11:0];
			if (reg_addr_in == OFF_PORT_DAT)
				s_d.port_dat = reg_wdata_in[11:0];
		end

		// Register reads, data one cycle later
		s_d.rdata = 32'h00000000;
		if (reg_rd_in)
		begin
			for (int r = 0; r < NUM_REGIONS; r++)
			begin
				if (reg_addr_in == 8'(OFF_REGION + 8'(r) * REGION_STRIDE))
					s_d.rdata = {s_q.base[r], 12'h000};
				if (reg_addr_in == 8'(OFF_REGION + 8'(r) * REGION_STRIDE + OFF_REGION_OPT))
					s_d.rdata = {s_q.mask[r], 7'h00, s_q.w16[r], s_q.pipe[r], s_q.wst[r]};
			end
			for (int p = 0; p <= NUM_PINS; p++)
				if (reg_addr_in == 8'(OFF_PIN + 8'(p) * PIN_STRIDE))
					s_d.rdata = {25'h0000000, s_q.sel[p], 2'h0, s_q.role[p]};
			for (int k = 0; k < 2; k++)
			begin
				if (reg_addr_in == 8'(OFF_SUB + 8'(k) * REGION_STRIDE))
					s_d.rdata = {s_q.sub_base[k], 12'h000};
				if (reg_addr_in == 8'(OFF_SUB + 8'(k) * REGION_STRIDE + OFF_REGION_OPT))
					s_d.rdata = {s_q.sub_mask[k], 11'h000, s_q.sub_wp[k]};
			end
			if (reg_addr_in == OFF_PORT_SEL)
				s_d.rdata = {20'h00000, s_q.port_sel};
			if (reg_addr_in == OFF_PORT_DAT)
				s_d.rdata = {20'h00000, s_q.port_dat};
			if (reg_addr_in == OFF_STATUS)
				s_d.rdata = {20'h00000, s_q.act_cnt, s_q.pend_rg, s_q.act_rg,
					s_q.pend_wr, s_q.pend_v, s_q.act_v};
		end

		// Pin levels from the next access state
		for (int p = 0; p <= NUM_PINS; p++)
		begin
			rg = (p == BOOT_PIN) ? 3'h0 : 3'(p);
			case (s_d.role[p])
				ROLE_CE: s_d.pin_lvl[p] = !((s_d.pend_v && s_d.pend_rg == rg) // RQ10
					|| (s_d.act_v && s_d.act_rg == rg && !s_d.pipe[rg])); // RQ11
				ROLE_WE: s_d.pin_lvl[p] = !(s_d.act_v && s_d.act_wr
					&& s_d.act_rg == s_d.sel[p]); // RQ13
				ROLE_OE: s_d.pin_lvl[p] = !(s_d.act_v && !s_d.act_wr
					&& s_d.act_rg == s_d.sel[p]); // RQ15
				ROLE_ALT: s_d.pin_lvl[p] = (p == BOOT_PIN) ? 1'b1
					: (s_d.port_sel[p % NUM_PINS] ? s_d.port_dat[p % NUM_PINS]
					: s_d.ext_a[31 - (p % NUM_PINS)]); // RQ2 RQ23
				default: s_d.pin_lvl[p] = 1'b1;
			endcase
		end

		// Synchronous reset overrides everything
		if (rst_in)
		begin
			s_d = '0; // RQ9
			for (int r = 0; r < NUM_REGIONS; r++)
			begin
				s_d.base[r] = RST_BASE;
				s_d.mask[r] = RST_MASK;
				s_d.wst[r] = RST_WAIT;
			end
			for (int p = 0; p <= NUM_PINS; p++)
			begin
				s_d.role[p] = ROLE_ALT;
				s_d.sel[p] = RST_SEL;
			end
			s_d.role[BOOT_PIN] = ROLE_CE; // RQ4
			s_d.role[0] = ROLE_OE; // RQ5
			s_d.port_sel = RST_PORT;
			s_d.port_dat = RST_PORT;
			s_d.pin_lvl[BOOT_PIN] = 1'b1;
			s_d.pin_lvl[0] = 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk_in)
	begin
		s_q <= s_d;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// All outputs come from state flops
	assign reg_rdata_out = s_q.rdata;
	assign aack_out = s_q.aack;
	assign ta_out = s_q.ta;
	assign err_out = s_q.err;
	assign ext_addr_out = s_q.ext_a;
	assign ext_write_out = s_q.ext_wr;
	assign port16_out = s_q.w16_o;
	assign select_pin_out = s_q.pin_lvl[NUM_PINS-1:0]; // RQ8
	assign boot_select_pin_n_out = s_q.pin_lvl[BOOT_PIN];

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	a_boot_no_alt: assert property (s_q.role[BOOT_PIN] != ROLE_ALT) // RQ3
		else $error("boot select pin in alternate role");
	a_pin0_no_ce: assert property (s_q.role[0] != ROLE_CE && s_q.role[7] != ROLE_CE) // RQ5
		else $error("pin 0 or 7 in chip enable role");
	a_high_no_ce: assert property (s_q.role[11] != ROLE_CE && s_q.role[6] != ROLE_CE) // RQ7
		else $error("pin 6 or 11 in chip enable role");
	a_ce_with_addr: assert property (aack_out && s_q.pend_rg == 3'h0
		&& s_q.role[BOOT_PIN] == ROLE_CE |-> !boot_select_pin_n_out) // RQ10
		else $error("boot chip enable missing with address");
	a_ce_hold: assert property (s_q.act_v && s_q.act_rg == 3'h0 && !s_q.pipe[0]
		&& s_q.role[BOOT_PIN] == ROLE_CE |-> !boot_select_pin_n_out) // RQ11
		else $error("non-pipelined chip enable dropped early");
	a_we_write_only: assert property (s_q.role[6] == ROLE_WE && !select_pin_out[6]
		|-> s_q.act_v && s_q.act_wr) // RQ13
		else $error("write enable outside write data phase");
	a_oe_read_only: assert property (s_q.role[0] == ROLE_OE && !select_pin_out[0]
		|-> s_q.act_v && !s_q.act_wr) // RQ15
		else $error("output enable outside read data phase");
	a_wait_count: assert property (s_q.act_v && s_q.act_cnt == 3'h2
		|=> !ta_out ##1 ta_out) // RQ16
		else $error("wait state count wrong");
	a_two_regions: assert property (s_q.pend_v && s_q.act_v && s_q.act_cnt != 3'h0
		|-> s_q.pend_rg != s_q.act_rg) // RQ17
		else $error("two outstanding to one region");
	a_alt_source: assert property (s_q.role[4] == ROLE_ALT |-> select_pin_out[4]
		== (s_q.port_sel[4] ? s_q.port_dat[4] : ext_addr_out[27])) // RQ23
		else $error("alternate pin not from its source");
	a_protect_err: assert property (err_out |-> !$past(s_q.aack) && !aack_out) // RQ20
		else $error("refused access acknowledged");

	c_back_to_back: cover property (aack_out ##[1:8] aack_out ##[1:8] ta_out);
	c_wait_seven: cover property (s_q.act_v && s_q.act_cnt == 3'h7);
	c_refused: cover property (err_out);
	c_overlap: cover property (s_q.pend_v && s_q.act_v);

endmodule

// File: verif/mem_slave_model.sv
// Purpose: Behavioural external memory seen through the select strobes
// Assumes: Strobes active low, one clock shared with the select unit
// Notes:   No data bus exists at the unit's ports; only strobes and the address are modelled
`timescale 1ns/1ps
module mem_slave_model
(
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// Strobes, active low
	input  wire logic        ce_n_in,
	input  wire logic        we_n_in,
	input  wire logic        oe_n_in,
	// External address
	input  wire logic [31:0] addr_in,
	// What the memory saw
	output logic      [31:0] cap_addr_out,
	output logic      [7:0]  wr_count_out,
	output logic             drive_out
);
	// ----------------------------------------
	// Synchronous capture
	// ----------------------------------------
	// Address taken on edges with enable low, write data counted on edges with WE low
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			wr_count_out <= 8'h00;
		else if (!we_n_in)
			wr_count_out <= wr_count_out + 8'h01;
		if (!ce_n_in)
			cap_addr_out <= addr_in;
	end

	// Read data driven only while output enable is low
	assign drive_out = !oe_n_in;
endmodule

// File: verif/chip_select_pin_control_bench.sv
// Purpose: Self-checking bench for the chip-select pin control unit
// Assumes: Register map and timing as handed over with the design
// Notes:   Random addresses from a fixed xorshift seed
`timescale 1ns/1ps
module chip_select_pin_control_bench;
	// Stimulus
	logic        clk_in       = 1'b0;
	logic        rst_in       = 1'b1;
	logic [7:0]  reg_addr_in  = 8'h00;
	logic [31:0] reg_wdata_in = 32'h0;
	logic        reg_wr_in    = 1'b0;
	logic        reg_rd_in    = 1'b0;
	logic        req_valid_in = 1'b0;
	logic [31:0] req_addr_in  = 32'h0;
	logic        req_write_in = 1'b0;
	// Observed
	logic [31:0] reg_rdata_out, ext_addr_out, cap_addr;
	logic        aack_out, ta_out, err_out, ext_write_out, port16_out;
	logic        boot_select_pin_n_out, drive;
	logic [11:0] select_pin_out;
	logic [7:0]  wr_count;
	// Bench state
	int          bad_count = 0;
	int          n_tests   = 0;
	int          cycles    = 0;
	int          na, nt, ak, ak2, tk;
	logic [31:0] seed      = 32'hC083DD0A;
	logic [31:0] a, d;

	cs_unit uut
	(
		.clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
		.reg_rdata_out, .req_valid_in, .req_addr_in, .req_write_in, .aack_out, .ta_out,
		.err_out, .ext_addr_out, .ext_write_out, .port16_out, .select_pin_out,
		.boot_select_pin_n_out
	);
	mem_slave_model slave
	(
		.clk_in, .rst_in, .ce_n_in(boot_select_pin_n_out), .we_n_in(select_pin_out[6]),
		.oe_n_in(select_pin_out[0]), .addr_in(ext_addr_out), .cap_addr_out(cap_addr),
		.wr_count_out(wr_count), .drive_out(drive)
	);

	// 40 MHz clock
	always #12.5 clk_in = ~clk_in;

	// Hang limit
	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			bad_count++;
			print_verdict();
		end
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Alternate pin p shows bus address bit 31 - p
	function automatic logic [11:0] alt_bits(input logic [31:0] ad);
		logic [11:0] b;
		for (int p = 0; p < 12; p++)
			b[p] = ad[31 - p];
		return b;
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic reg_wr(input logic [7:0] ad, input logic [31:0] dv);
		@(posedge clk_in);
		reg_addr_in  <= ad;
		reg_wdata_in <= dv;
		reg_wr_in    <= 1'b1;
		@(posedge clk_in);
		reg_wr_in    <= 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] ad, input logic [31:0] ex);
		@(posedge clk_in);
		reg_addr_in <= ad;
		reg_rd_in   <= 1'b1;
		@(posedge clk_in);
		reg_rd_in   <= 1'b0;
		#1;
		check("reg_read", reg_rdata_out, ex);
	endtask

	// One access to region 0: boot CE, pin 0 OE, pin 6 WE
	task automatic access(input logic [31:0] ad, input logic wr, input int w,
		input logic p16, input logic ex_err);
		int         n;
		logic [7:0] w0;
		@(posedge clk_in);
		req_addr_in  <= ad;
		req_write_in <= wr;
		req_valid_in <= 1'b1;
		w0 = wr_count;
		n = 0;
		do
		begin
			@(posedge clk_in);
			#1;
			n++;
		end
		while (aack_out !== 1'b1 && err_out !== 1'b1 && n < 40);
		check("refused", 32'(err_out), 32'(ex_err));
		if (!ex_err)
		begin
			check("ce_addr", ext_addr_out, ad);
			check("ce_on", 32'(boot_select_pin_n_out), 32'h0);
		end
		@(posedge clk_in);
		req_valid_in <= 1'b0;
		if (ex_err)
			return;
		n = 0;
		do
		begin
			#1;
			n++;
			check("ce_hold", 32'(boot_select_pin_n_out), 32'h0);
			check("slave_drive", 32'(drive), 32'(!wr));
			check("we_pin", 32'(select_pin_out[6]), 32'(!wr));
			check("port16", 32'(port16_out), 32'(p16));
			if (ta_out !== 1'b1)
				@(posedge clk_in);
		end
		while (ta_out !== 1'b1 && n < 20);
		check("wait_states", 32'(n), 32'(w + 1));
		check("slave_addr", cap_addr, ad);
		@(posedge clk_in);
		#1;
		check("released", 32'({boot_select_pin_n_out, select_pin_out[0], select_pin_out[6]}),
			32'h7);
		check("we_cycles", 32'(wr_count - w0), wr ? 32'(w + 1) : 32'h0);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (12) @(posedge clk_in);
		rst_in <= 1'b0;
		#1;
		check("reset_pins", 32'({boot_select_pin_n_out, select_pin_out}), 32'h1001);
		reg_rd(8'h04, 32'h7);
		reg_rd(8'h40, 32'h3);
		reg_rd(8'h70, 32'h1);
		reg_rd(8'h74, 32'h0);
		$display("test reset done");
		// Every role code on a pin that accepts all of them
		for (int r = 0; r < 4; r++)
		begin
			reg_wr(8'h48, 32'(r));
			reg_rd(8'h48, 32'(r));
		end
		reg_wr(8'h48, 32'h0);
		reg_wr(8'h5C, 32'h21);
		reg_rd(8'h5C, 32'h20);
		reg_wr(8'h70, 32'h0);
		reg_rd(8'h70, 32'h1);
		reg_wr(8'h40, 32'h1);
		reg_rd(8'h40, 32'h3);
		reg_wr(8'h5C, 32'h0);
		reg_wr(8'h58, 32'h2);
		$display("test roles done");
		// Alternate pins follow address, then port data
		repeat (4)
		begin
			a = rnd();
			access(a, 1'b0, 7, 1'b0, 1'b0);
			check("alt_addr", 32'(select_pin_out & 12'hFBE), 32'(alt_bits(a) & 12'hFBE));
		end
		reg_wr(8'h90, 32'hFFF);
		d = rnd();
		reg_wr(8'h94, d);
		repeat (2) @(posedge clk_in);
		#1;
		check("alt_port", 32'(select_pin_out & 12'hFBE), 32'(d[11:0] & 12'hFBE));
		reg_wr(8'h90, 32'h0);
		$display("test alternate done");
		// Every wait count, reads and writes, both port widths
		for (int w = 0; w < 8; w++)
		begin
			reg_wr(8'h04, 32'(w) | (w[1] ? 32'h10 : 32'h0));
			access(rnd(), w[0], w, w[1], 1'b0);
		end
		$display("test waits done");
		reg_wr(8'h84, 32'h1);
		access(rnd(), 1'b1, 7, 1'b1, 1'b1);
		access(rnd(), 1'b0, 7, 1'b1, 1'b0);
		reg_wr(8'h84, 32'h0);
		$display("test protect done");
		// Pipelined region 1 with back-to-back reads
		reg_wr(8'h04, 32'h8000_0000);
		reg_wr(8'h08, 32'h8000_0000);
		reg_wr(8'h0C, 32'h8000_000A);
		reg_wr(8'h44, 32'h1);
		@(posedge clk_in);
		req_addr_in  <= 32'h8000_0100;
		req_write_in <= 1'b0;
		req_valid_in <= 1'b1;
		na = 0;
		nt = 0;
		for (int c = 1; c < 16; c++)
		begin
			@(posedge clk_in);
			if (na == 2)
				req_valid_in <= 1'b0;
			#1;
			check("pipe_ce", 32'(select_pin_out[1]), 32'(!aack_out));
			if (aack_out === 1'b1)
			begin
				na++;
				ak2 = c;
				if (na == 1)
					ak = c;
			end
			if (ta_out === 1'b1)
			begin
				nt++;
				if (nt == 1)
					tk = c;
			end
		end
		check("pipe_aacks", 32'(na), 32'h2);
		check("pipe_tas", 32'(nt), 32'h2);
		check("pipe_wait", 32'(tk - ak), 32'h3);
		check("overlap", 32'(ak2 <= tk), 32'h1);
		$display("test pipeline done");
		print_verdict();
	end
endmodule
